// *** rtl/exec_pkg.sv ***
// Purpose: shared types and constants for the store, bit and flag execution unit
// Assumes: single 200 MHz clock, operands fetched by the decoder before issue
// Notes: status register bit order is I T H S V N Z C from bit 7 down
// Contract
// RULE1 - pointer write stores source at Z; post-increment form then bumps Z; one cycle.
// RULE2 - pre-decrement form lowers Z first, stores at new Z; one cycle, no flags.
// RULE3 - offset write stores at Z plus q, Z kept, one cycle, no flags.
// RULE4 - code memory read loads byte at Z into R-first or Rd; 3 cycles; optional Z+1.
// RULE5 - port read copies I/O(A) to Rd; port write copies Rr out; one cycle.
// RULE6 - stack save takes one cycle; stack pull takes two cycles; no flags.
// RULE7 - left shifts: bit7 to C, bit0 gets C or 0; Z,C,N,V,H updated.
// RULE8 - right shifts: bit0 to C, bit7 gets C, 0 or kept; Z,C,N,V updated.
// RULE9 - io bit set forces bit b of I/O(A) high in one cycle, no flags.
// RULE10 - io bit clear forces bit b of I/O(A) low in one cycle, no flags.
// RULE11 - register bit to T copies Rr(b) into T, only T changes.
// RULE12 - T to register bit copies T into Rd(b), no flag changes.
// RULE13 - overflow set and clear drive V only, in one cycle.
// RULE14 - half-carry set and clear drive H only, in one cycle.
// RULE15 - signed, C, N, Z, T and I set and clear change one flag, one cycle.
// RULE16 - break, no-op, sleep, watchdog restart take one cycle and signal their unit.
// RULE17 - data writes into the nonvolatile region take at least one extra cycle.
// RULE18 - nibble exchange swaps the halves of Rd in one cycle, no flags.
// RULE19 - flag raise and lower pick the status bit by a 3-bit index.
package exec_pkg;

    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam logic [4:0] FIRST_WORKING_REG = 5'h00;
    // data addresses at or above this go through the nonvolatile memory controller
    localparam logic [15:0] NVM_BASE = 16'h8000;

    typedef enum logic [4:0] {
        OP_NOP,
        OP_PTR_PLAIN,
        OP_PTR_POSTINC,
        OP_PTR_PREDEC,
        OP_PTR_OFFSET,
        OP_CODE_FIRST,
        OP_CODE_RD,
        OP_CODE_RD_INC,
        OP_PORT_READ,
        OP_PORT_WRITE,
        OP_STACK_SAVE,
        OP_STACK_PULL,
        OP_SHL_ZERO,
        OP_SHR_ZERO,
        OP_ROTL_CARRY,
        OP_ROTR_CARRY,
        OP_SHR_SIGN,
        OP_NIBBLE_SWAP,
        OP_IO_BIT_SET,
        OP_IO_BIT_CLEAR,
        OP_REG_BIT_TO_T,
        OP_T_TO_REG_BIT,
        OP_FLAG_RAISE,
        OP_FLAG_LOWER,
        OP_BREAK,
        OP_SLEEP,
        OP_WATCHDOG_RESTART
    } op_t;

    typedef struct packed {
        op_t op;
        logic [4:0] rdIdx;
        logic [7:0] rdVal;
        logic [7:0] rrVal;
        logic [15:0] zVal;
        logic [5:0] disp;
        logic [5:0] ioAddr;
        logic [7:0] ioVal;
        logic [2:0] bitIdx;
    } cmd_t;

    typedef struct packed {
        logic we;
        logic [4:0] addr;
        logic [7:0] data;
    } regwr_t;

    typedef struct packed {
        logic we;
        logic [15:0] addr;
        logic [7:0] data;
    } memwr_t;

    typedef struct packed {
        logic we;
        logic [5:0] addr;
        logic [7:0] data;
    } iowr_t;

    typedef struct packed {
        logic we;
        logic [15:0] value;
    } zwr_t;

endpackage

// *** rtl/exec_unit.sv ***
// Purpose: executes pointer stores, code memory reads, port, stack, shift, bit and flag ops
// Assumes: decoder supplies operand values and current I/O contents with each command
// Notes: writes and strobes are registered and valid the cycle after acceptance; code read and stack pull register writes come two and one cycles later
`timescale 1ns/1ps
module exec_unit
    import exec_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic cmdValid,
    output logic cmdReady,
    input wire cmd_t cmd,
    output regwr_t regWrite,
    output memwr_t memWrite,
    input wire logic memReady,
    output iowr_t ioWrite,
    output zwr_t zWrite,
    output logic codeRead,
    output logic [15:0] codeAddr,
    input wire logic [7:0] codeData,
    output logic stackPush,
    output logic [7:0] stackPushData,
    output logic stackPull,
    input wire logic [7:0] stackPullData,
    output logic [7:0] statusOut,
    output logic breakPulse,
    output logic sleepPulse,
    output logic watchdogRestartPulse
);

    typedef enum logic [2:0] {
        S_IDLE,
        S_CODE1,
        S_CODE2,
        S_PULL,
        S_MEMFIRST,
        S_MEMWAIT
    } state_t;

    // returns {carry, result}
    function automatic logic [8:0] shiftCalc(input op_t op, input logic [7:0] v, input logic c);
        case (op)
            OP_SHL_ZERO: shiftCalc = {v[7], v[6:0], 1'b0};
            OP_ROTL_CARRY: shiftCalc = {v[7], v[6:0], c};
            OP_SHR_ZERO: shiftCalc = {v[0], 1'b0, v[7:1]};
            OP_ROTR_CARRY: shiftCalc = {v[0], c, v[7:1]};
            OP_SHR_SIGN: shiftCalc = {v[0], v[7], v[7:1]};
            default: shiftCalc = {c, v};
        endcase
    endfunction

    // s is left alone: only the listed flags move for shifts
    function automatic logic [7:0] shiftFlags(input op_t op, input logic [7:0] v,
                                              input logic [8:0] r, input logic [7:0] s);
        logic [7:0] f;
        logic n;
        f = s;
        n = r[7];
        f[FLAG_C] = r[8];
        f[FLAG_Z] = (r[7:0] == 8'h00);
        f[FLAG_N] = n;
        f[FLAG_V] = n ^ r[8];
        if (op == OP_SHL_ZERO || op == OP_ROTL_CARRY) begin
            f[FLAG_H] = v[3];
        end
        shiftFlags = f;
    endfunction

    state_t state_reg, state_next;
    logic [7:0] status_reg, status_next;
    regwr_t regWrite_reg, regWrite_next;
    memwr_t memWrite_reg, memWrite_next;
    iowr_t ioWrite_reg, ioWrite_next;
    zwr_t zWrite_reg, zWrite_next;
    logic codeRead_reg, codeRead_next;
    logic [15:0] codeAddr_reg, codeAddr_next;
    logic stackPush_reg, stackPull_reg;
    logic [7:0] stackPushData_reg, stackPushData_next;
    logic breakPulse_reg, sleepPulse_reg, watchdog_reg;
    logic [4:0] pendDest_reg, pendDest_next;

    wire logic take = cmdValid && cmdReady;
    wire op_t op = cmd.op;
    wire logic isPtr = op inside {OP_PTR_PLAIN, OP_PTR_POSTINC, OP_PTR_PREDEC, OP_PTR_OFFSET};
    wire logic isCode = op inside {OP_CODE_FIRST, OP_CODE_RD, OP_CODE_RD_INC};
    wire logic isShift = op inside {OP_SHL_ZERO, OP_SHR_ZERO, OP_ROTL_CARRY, OP_ROTR_CARRY,
                                    OP_SHR_SIGN};
    wire logic [15:0] zDec = cmd.zVal - 16'h0001;
    wire logic [15:0] zInc = cmd.zVal + 16'h0001;
    wire logic [15:0] ptrAddr = (op == OP_PTR_PREDEC) ? zDec : // RULE2
                                (op == OP_PTR_OFFSET) ? cmd.zVal + {10'h000, cmd.disp} : // RULE3
                                cmd.zVal; // RULE1
    wire logic ptrNvm = ptrAddr >= NVM_BASE;
    wire logic [8:0] shifted = shiftCalc(op, cmd.rdVal, status_reg[FLAG_C]); // RULE7 RULE8
    wire logic [7:0] bitMask = 8'h01 << cmd.bitIdx;
    wire logic [7:0] tInserted = status_reg[FLAG_T] ? (cmd.rdVal | bitMask)
                                                    : (cmd.rdVal & ~bitMask); // RULE12
    wire logic [7:0] swapped = {cmd.rdVal[3:0], cmd.rdVal[7:4]}; // RULE18
    wire logic [7:0] regData = isShift ? shifted[7:0] :
                               (op == OP_NIBBLE_SWAP) ? swapped :
                               (op == OP_T_TO_REG_BIT) ? tInserted :
                               cmd.ioVal; // RULE5
    wire logic regOp = isShift || op inside {OP_NIBBLE_SWAP, OP_T_TO_REG_BIT, OP_PORT_READ};
    wire logic [7:0] ioData = (op == OP_IO_BIT_SET) ? (cmd.ioVal | bitMask) : // RULE9
                              (op == OP_IO_BIT_CLEAR) ? (cmd.ioVal & ~bitMask) : // RULE10
                              cmd.rrVal; // RULE5
    wire logic ioOp = op inside {OP_PORT_WRITE, OP_IO_BIT_SET, OP_IO_BIT_CLEAR};
    wire logic [7:0] flagMask = 8'h01 << cmd.bitIdx; // RULE19
    wire logic [7:0] statusAfter =
        isShift ? shiftFlags(op, cmd.rdVal, shifted, status_reg) :
        (op == OP_REG_BIT_TO_T) ? ((status_reg & ~(8'h01 << FLAG_T)) |
                                   ({7'h00, cmd.rrVal[cmd.bitIdx]} << FLAG_T)) : // RULE11
        (op == OP_FLAG_RAISE) ? (status_reg | flagMask) : // RULE13 RULE14 RULE15
        (op == OP_FLAG_LOWER) ? (status_reg & ~flagMask) : // RULE13 RULE14 RULE15
        status_reg;

    assign cmdReady = (state_reg == S_IDLE);

    always_comb begin
        state_next = state_reg;
        status_next = status_reg;
        regWrite_next = '0;
        memWrite_next = '0;
        ioWrite_next = '0;
        zWrite_next = '0;
        codeRead_next = 1'b0;
        codeAddr_next = codeAddr_reg;
        stackPushData_next = stackPushData_reg;
        pendDest_next = pendDest_reg;
        case (state_reg)
            S_IDLE: begin
                if (take) begin
                    status_next = statusAfter;
                    if (regOp) begin
                        regWrite_next = '{we: 1'b1, addr: cmd.rdIdx, data: regData};
                    end
                    if (ioOp) begin
                        ioWrite_next = '{we: 1'b1, addr: cmd.ioAddr, data: ioData};
                    end
                    if (isPtr) begin
                        memWrite_next = '{we: 1'b1, addr: ptrAddr, data: cmd.rrVal}; // RULE1
                        if (ptrNvm) begin
                            state_next = S_MEMFIRST; // RULE17
                        end
                    end
                    if (op == OP_PTR_POSTINC) begin
                        zWrite_next = '{we: 1'b1, value: zInc}; // RULE1
                    end
                    if (op == OP_PTR_PREDEC) begin
                        zWrite_next = '{we: 1'b1, value: zDec}; // RULE2
                    end
                    if (isCode) begin
                        codeRead_next = 1'b1; // RULE4
                        codeAddr_next = cmd.zVal;
                        pendDest_next = (op == OP_CODE_FIRST) ? FIRST_WORKING_REG : cmd.rdIdx;
                        state_next = S_CODE1;
                    end
                    if (op == OP_CODE_RD_INC) begin
                        zWrite_next = '{we: 1'b1, value: zInc}; // RULE4
                    end
                    if (op == OP_STACK_SAVE) begin
                        stackPushData_next = cmd.rrVal; // RULE6
                    end
                    if (op == OP_STACK_PULL) begin
                        pendDest_next = cmd.rdIdx;
                        state_next = S_PULL; // RULE6
                    end
                end
            end
            S_CODE1: begin
                state_next = S_CODE2;
            end
            S_CODE2: begin
                regWrite_next = '{we: 1'b1, addr: pendDest_reg, data: codeData}; // RULE4
                state_next = S_IDLE;
            end
            S_PULL: begin
                regWrite_next = '{we: 1'b1, addr: pendDest_reg, data: stackPullData}; // RULE6
                state_next = S_IDLE;
            end
            S_MEMFIRST: begin
                // an accept seen this early is ignored, so the slow store always keeps its extra cycle
                memWrite_next = memWrite_reg;
                state_next = S_MEMWAIT; // RULE17
            end
            S_MEMWAIT: begin
                // hold the write until the controller takes it; the wait is never shorter
                memWrite_next = memWrite_reg;
                if (memReady) begin
                    memWrite_next = '0;
                    state_next = S_IDLE; // RULE17
                end
            end
            default: begin
                state_next = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= S_IDLE;
            status_reg <= STATUS_RESET;
            regWrite_reg <= '0;
            memWrite_reg <= '0;
            ioWrite_reg <= '0;
            zWrite_reg <= '0;
            codeRead_reg <= 1'b0;
            codeAddr_reg <= 16'h0000;
            pendDest_reg <= 5'h00;
            stackPushData_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            status_reg <= status_next;
            regWrite_reg <= regWrite_next;
            memWrite_reg <= memWrite_next;
            ioWrite_reg <= ioWrite_next;
            zWrite_reg <= zWrite_next;
            codeRead_reg <= codeRead_next;
            codeAddr_reg <= codeAddr_next;
            pendDest_reg <= pendDest_next;
            stackPushData_reg <= stackPushData_next;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stackPush_reg <= 1'b0;
            stackPull_reg <= 1'b0;
            breakPulse_reg <= 1'b0;
            sleepPulse_reg <= 1'b0;
            watchdog_reg <= 1'b0;
        end else begin
            stackPush_reg <= take && (op == OP_STACK_SAVE); // RULE6
            stackPull_reg <= take && (op == OP_STACK_PULL); // RULE6
            breakPulse_reg <= take && (op == OP_BREAK); // RULE16
            sleepPulse_reg <= take && (op == OP_SLEEP); // RULE16
            watchdog_reg <= take && (op == OP_WATCHDOG_RESTART); // RULE16
        end
    end

    assign regWrite = regWrite_reg;
    assign memWrite = memWrite_reg;
    assign ioWrite = ioWrite_reg;
    assign zWrite = zWrite_reg;
    assign codeRead = codeRead_reg;
    assign codeAddr = codeAddr_reg;
    assign stackPush = stackPush_reg;
    assign stackPushData = stackPushData_reg;
    assign stackPull = stackPull_reg;
    assign statusOut = status_reg;
    assign breakPulse = breakPulse_reg;
    assign sleepPulse = sleepPulse_reg;
    assign watchdogRestartPulse = watchdog_reg;

endmodule

// *** bench/exec_unit_props.sv ***
// Purpose: port-level checks on the execution unit
// Assumes: one clock domain, asynchronous active-high reset
// Notes: expected values come from the command and status seen at the accepting edge; code read data from the cycle before the write
`timescale 1ns/1ps
module exec_unit_props
    import exec_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic cmdValid,
    input wire logic cmdReady,
    input wire cmd_t cmd,
    input wire regwr_t regWrite,
    input wire memwr_t memWrite,
    input wire iowr_t ioWrite,
    input wire zwr_t zWrite,
    input wire logic codeRead,
    input wire logic [15:0] codeAddr,
    input wire logic [7:0] codeData,
    input wire logic [7:0] statusOut
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence s_take(op_t o);
        cmdValid && cmdReady && cmd.op == o;
    endsequence
    sequence s_code_wait;
        (codeRead && !cmdReady) ##1 !cmdReady;
    endsequence
    property p_post_inc;
        s_take(OP_PTR_POSTINC) |=> memWrite.we && memWrite.addr == $past(cmd.zVal)
            && zWrite.we && zWrite.value == $past(cmd.zVal) + 16'h0001;
    endproperty
    a_post_inc: assert property (p_post_inc) else $error("post-increment store wrong");
    property p_pre_dec;
        s_take(OP_PTR_PREDEC) |=> memWrite.addr == $past(cmd.zVal) - 16'h0001
            && zWrite.value == memWrite.addr && $stable(statusOut);
    endproperty
    a_pre_dec: assert property (p_pre_dec) else $error("pre-decrement store wrong");
    property p_offset;
        s_take(OP_PTR_OFFSET) |=> memWrite.we && !zWrite.we
            && memWrite.addr == $past(cmd.zVal) + {10'h000, $past(cmd.disp)};
    endproperty
    a_offset: assert property (p_offset) else $error("offset store wrong");
    property p_code;
        s_take(OP_CODE_RD) |=> (codeAddr == $past(cmd.zVal)) ##0 s_code_wait ##1
            (regWrite.we && regWrite.addr == $past(cmd.rdIdx, 3)
            && regWrite.data == $past(codeData));
    endproperty
    a_code: assert property (p_code) else $error("code read wrong");
    property p_shl;
        s_take(OP_SHL_ZERO) |=> regWrite.data == {$past(cmd.rdVal[6:0]), 1'b0}
            && statusOut[FLAG_C] == $past(cmd.rdVal[7])
            && statusOut[FLAG_S] == $past(statusOut[FLAG_S]);
    endproperty
    a_shl: assert property (p_shl) else $error("left shift wrong");
    property p_io_set;
        s_take(OP_IO_BIT_SET) |=> ioWrite.we && ioWrite.addr == $past(cmd.ioAddr)
            && ioWrite.data == ($past(cmd.ioVal) | (8'h01 << $past(cmd.bitIdx)))
            && $stable(statusOut);
    endproperty
    a_io_set: assert property (p_io_set) else $error("io bit set wrong");
    property p_raise;
        s_take(OP_FLAG_RAISE) |=> statusOut == ($past(statusOut) | (8'h01 << $past(cmd.bitIdx)));
    endproperty
    a_raise: assert property (p_raise) else $error("flag raise wrong");
    property p_swap;
        s_take(OP_NIBBLE_SWAP) |=> regWrite.we
            && regWrite.data == {$past(cmd.rdVal[3:0]), $past(cmd.rdVal[7:4])} && $stable(statusOut);
    endproperty
    a_swap: assert property (p_swap) else $error("nibble swap wrong");
    property p_nvm_hold;
        $rose(memWrite.we) && memWrite.addr >= NVM_BASE |=> memWrite.we;
    endproperty
    a_nvm_hold: assert property (p_nvm_hold) else $error("slow store too short");
endmodule

// *** bench/mem_partner.sv ***
// Purpose: far side model of program memory, stack and nonvolatile store path
// Assumes: codeAddr holds during a code read
// Notes: outside its reply window each data output toggles every cycle
`timescale 1ns/1ps
module mem_partner
    import exec_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic codeRead,
    input wire logic [15:0] codeAddr,
    input wire logic stackPull,
    input wire memwr_t memWrite,
    input wire logic [3:0] nvmDelay,
    output logic [7:0] codeData,
    output logic [7:0] stackPullData,
    output logic memReady
);
    logic [1:0] codeAge_reg;
    logic pullAge_reg;
    logic [3:0] waitCnt_reg;
    logic [7:0] junk_reg;
    logic nvmBusy;
    assign nvmBusy = memWrite.we && memWrite.addr >= NVM_BASE;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            codeAge_reg <= 2'b00;
            pullAge_reg <= 1'b0;
            waitCnt_reg <= 4'h0;
            junk_reg <= 8'h55;
        end else begin
            codeAge_reg <= {codeAge_reg[0], codeRead};
            pullAge_reg <= stackPull;
            waitCnt_reg <= (nvmBusy && !memReady) ? waitCnt_reg + 4'h1 : 4'h0;
            junk_reg <= ~junk_reg;
        end
    end
    assign codeData = (codeAge_reg != 2'b00) ? (codeAddr[7:0] ^ 8'h3c) : junk_reg;
    // covers both registered and direct capture of the pulled byte
    assign stackPullData = (stackPull || pullAge_reg) ? 8'hc3 : junk_reg;
    // a busy controller stretches the store; nvmDelay 0 answers at once
    assign memReady = nvmBusy && (waitCnt_reg >= nvmDelay);
endmodule

// *** bench/tb_top.sv ***
// Purpose: directed bench for the execution unit
// Assumes: far side modelled by mem_partner
// Notes: outputs are judged at the falling edge inside the cycle they belong to
`timescale 1ns/1ps
module tb_top;
    import exec_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cmdValid = 1'b0;
    cmd_t cmd = '0;
    logic [3:0] nvmDelay = 4'h0;
    logic cmdReady, memReady, codeRead, stackPush, stackPull, breakPulse, sleepPulse, wdPulse;
    regwr_t regWrite;
    memwr_t memWrite;
    iowr_t ioWrite;
    zwr_t zWrite;
    logic [15:0] codeAddr;
    logic [7:0] codeData, pushData, pullData, statusOut;
    int miscompares = 0;
    int num_checks = 0;
    int cycles = 0;
    always #2.5 clk = ~clk;
    exec_unit i_exec_unit(.clk(clk), .rst(rst), .cmdValid(cmdValid), .cmdReady(cmdReady),
        .cmd(cmd), .regWrite(regWrite), .memWrite(memWrite), .memReady(memReady),
        .ioWrite(ioWrite), .zWrite(zWrite), .codeRead(codeRead), .codeAddr(codeAddr),
        .codeData(codeData), .stackPush(stackPush), .stackPushData(pushData),
        .stackPull(stackPull), .stackPullData(pullData), .statusOut(statusOut),
        .breakPulse(breakPulse), .sleepPulse(sleepPulse), .watchdogRestartPulse(wdPulse));
    mem_partner i_mem_partner(.clk(clk), .rst(rst), .codeRead(codeRead), .codeAddr(codeAddr),
        .stackPull(stackPull), .memWrite(memWrite), .nvmDelay(nvmDelay), .codeData(codeData),
        .stackPullData(pullData), .memReady(memReady));
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic cmd_t mk(op_t o, logic [7:0] rd, logic [7:0] rr, logic [15:0] z,
                                logic [2:0] b);
        mk = '{o, 5'h1d, rd, rr, z, 6'h3f, 6'h3f, rd, b};
    endfunction
    // returns in cycle 1 of the accepted command; valid dropped at the accepting edge
    task automatic issue(input cmd_t c);
        @(posedge clk);
        cmd <= c;
        cmdValid <= 1'b1;
        do @(posedge clk); while (cmdReady !== 1'b1);
        cmdValid <= 1'b0;
        @(negedge clk);
    endtask
    task automatic t_flags;
        logic [7:0] exp = 8'h00;
        for (int s = 0; s < 16; s++) begin
            issue(mk(s < 8 ? OP_FLAG_RAISE : OP_FLAG_LOWER, 8'h00, 8'h00, 16'h0, 3'(s)));
            exp = (s < 8) ? (exp | (8'h01 << s[2:0])) : (exp & ~(8'h01 << s[2:0]));
            chk(16'(statusOut), 16'(exp));
        end
    endtask
    task automatic t_ctrl;
        op_t o[4] = '{OP_NOP, OP_BREAK, OP_SLEEP, OP_WATCHDOG_RESTART};
        logic [2:0] pv[4] = '{3'b000, 3'b100, 3'b010, 3'b001};
        foreach (o[i]) begin
            issue(mk(o[i], 8'h00, 8'h00, 16'h0, 3'h0));
            chk(16'({breakPulse, sleepPulse, wdPulse, statusOut}), 16'({pv[i], 8'h00}));
            @(negedge clk);
            chk(16'({breakPulse, sleepPulse, wdPulse}), 16'h0000);
        end
    endtask
    task automatic t_shift;
        op_t o[7] = '{OP_SHL_ZERO, OP_ROTL_CARRY, OP_ROTR_CARRY, OP_SHR_SIGN, OP_SHR_ZERO,
                      OP_ROTL_CARRY, OP_ROTR_CARRY};
        logic [7:0] v[7] = '{8'h81, 8'h81, 8'h01, 8'h80, 8'h01, 8'h00, 8'h00};
        logic [7:0] r[7] = '{8'h02, 8'h03, 8'h80, 8'hc0, 8'h00, 8'h01, 8'h00};
        logic [4:0] f[7] = '{5'h09, 5'h09, 5'h05, 5'h0c, 5'h0b, 5'h00, 5'h02};
        logic [15:0] e;
        // bit 3 set on a left shift must raise the half-carry flag
        issue(mk(OP_SHL_ZERO, 8'h08, 8'h00, 16'h0, 3'h0));
        chk({regWrite.data, statusOut}, 16'h1020);
        foreach (o[i]) begin
            issue(mk(o[i], v[i], 8'h00, 16'h0, 3'h0));
            e = {3'h1, r[i], f[i]};
            chk({2'h0, regWrite.we, regWrite.data, statusOut[4:0]}, e);
        end
    endtask
    task automatic t_bits;
        issue(mk(OP_IO_BIT_SET, 8'h00, 8'h00, 16'h0, 3'h7));
        chk(16'(ioWrite), 16'h7f80);
        issue(mk(OP_IO_BIT_CLEAR, 8'hff, 8'h00, 16'h0, 3'h0));
        chk(16'(ioWrite), 16'h7ffe);
        issue(mk(OP_REG_BIT_TO_T, 8'h00, 8'h08, 16'h0, 3'h3));
        chk(16'(statusOut), 16'h0042);
        issue(mk(OP_T_TO_REG_BIT, 8'h00, 8'h00, 16'h0, 3'h5));
        chk(16'(regWrite), 16'h3d20);
        issue(mk(OP_NIBBLE_SWAP, 8'ha5, 8'h00, 16'h0, 3'h0));
        chk(16'(regWrite), 16'h3d5a);
        chk(16'(statusOut), 16'h0042);
    endtask
    task automatic t_code;
        op_t o[3] = '{OP_CODE_FIRST, OP_CODE_RD, OP_CODE_RD_INC};
        foreach (o[i]) begin
            issue(mk(o[i], 8'h00, 8'h00, 16'h1234, 3'h0));
            chk(codeAddr, 16'h1234);
            chk(16'({codeRead, cmdReady, zWrite.we}), {13'h0, 2'b10, i == 2});
            if (i == 2) chk(zWrite.value, 16'h1235);
            @(negedge clk);
            chk(16'(cmdReady), 16'h0000);
            @(negedge clk);
            chk(16'(regWrite), (i == 0) ? 16'h2008 : 16'h3d08);
        end
    endtask
    task automatic t_port_stack;
        issue(mk(OP_PORT_READ, 8'h96, 8'h00, 16'h0, 3'h0));
        chk(16'(regWrite), 16'h3d96);
        issue(mk(OP_PORT_WRITE, 8'h00, 8'h3c, 16'h0, 3'h0));
        chk(16'(ioWrite), 16'h7f3c);
        issue(mk(OP_STACK_SAVE, 8'h00, 8'he7, 16'h0, 3'h0));
        chk(16'({stackPush, pushData}), 16'h01e7);
        issue(mk(OP_STACK_PULL, 8'h00, 8'h00, 16'h0, 3'h0));
        chk(16'({stackPull, cmdReady, regWrite.we}), 16'h0004);
        @(negedge clk);
        chk(16'(regWrite), 16'h3dc3);
    endtask
    task automatic t_store;
        op_t o[4] = '{OP_PTR_OFFSET, OP_PTR_POSTINC, OP_PTR_PLAIN, OP_PTR_PREDEC};
        logic [15:0] z[4] = '{16'h7fc1, 16'h7fff, 16'h1000, 16'h0000};
        logic [15:0] a[4] = '{16'h8000, 16'h7fff, 16'h1000, 16'hffff};
        logic [15:0] nz[4] = '{16'h0000, 16'h8000, 16'h0000, 16'hffff};
        logic [15:0] e;
        foreach (o[i]) begin
            // the slow controller is used last so no earlier store is caught mid-wait
            @(posedge clk);
            nvmDelay <= (i == 3) ? 4'h3 : 4'h0;
            issue(mk(o[i], 8'h00, 8'ha5, z[i], 3'h0));
            chk(memWrite.addr, a[i]);
            e = {7'h01, nz[i] != 16'h0, 8'ha5};
            chk({6'h00, memWrite.we, zWrite.we, memWrite.data}, e);
            if (nz[i] != 16'h0) chk(zWrite.value, nz[i]);
            @(negedge clk);
            chk(16'({memWrite.we, cmdReady}), (a[i] >= NVM_BASE) ? 16'h0002 : 16'h0001);
        end
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            report_and_stop();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk(16'({cmdReady, statusOut}), 16'h0100);
        t_flags();
        t_ctrl();
        t_shift();
        t_bits();
        t_code();
        t_port_stack();
        t_store();
        report_and_stop();
    end
endmodule
bind exec_unit exec_unit_props i_exec_unit_props(.clk(clk), .rst(rst), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmd(cmd), .regWrite(regWrite), .memWrite(memWrite),
    .ioWrite(ioWrite), .zWrite(zWrite), .codeRead(codeRead), .codeAddr(codeAddr),
    .codeData(codeData), .statusOut(statusOut));
